// [hw/sacs_consts.vh]
// constants for the converter control sequencer
`ifndef SACS_CONSTS_VH
`define SACS_CONSTS_VH
// register byte addresses (index times four)
`define SACS_IDX_CTRL1 8'h1C
`define SACS_IDX_CTRL2 8'h1D
`define SACS_IDX_RESLO 8'h1E
`define SACS_IDX_RESHI 8'h1F
`define SACS_ADDR_W 10
`define SACS_ADDR_CTRL1 10'h070
`define SACS_ADDR_CTRL2 10'h074
`define SACS_ADDR_RESLO 10'h078
`define SACS_ADDR_RESHI 10'h07C
// reset values
`define SACS_CTRL1_RST 8'h10
`define SACS_CTRL2_RST 6'h10
`define SACS_RESHI_RST 8'h00
// control one fields
`define SACS_C1_START 7
`define SACS_C1_MODE_HI 6
`define SACS_C1_MODE_LO 5
`define SACS_C1_AINDIS 4
`define SACS_C1_CH_HI 3
// control two fields
`define SACS_C2_LADDER 5
`define SACS_C2_TIME_HI 3
`define SACS_C2_TIME_LO 1
// status fields
`define SACS_S_DONE 5
`define SACS_S_BUSY 4
// modes
`define SACS_MODE_OFF 2'h0
`define SACS_MODE_SINGLE 2'h1
`define SACS_MODE_REPEAT 2'h3
// conversion time in system clock periods per code
`define SACS_T0 11'h027
`define SACS_T2 11'h04E
`define SACS_T3 11'h09C
`define SACS_T4 11'h138
`define SACS_T5 11'h270
`define SACS_T6 11'h4E0
`define SACS_NBITS 4'hA
`endif

// [hw/sacs_sequencer.v]
// converter control sequencer with avalon-mm register slave
// Behaviour
// R1: single mode start bit begins one conversion
// R2: mode 00 off, 01 single, 11 repeat
// R3: four-bit channel code n selects input n
// R4: control one bit 4 disables analog inputs
// R5: start bit self-clears once conversion starts
// R6: software never restarts during running conversion
// R7: result, done flag, interrupt set together
// R8: result bits packed into high/low registers
// R9: reading high result clears done flag; code does so only while idle, never while a conversion runs
// R10: busy set at start, cleared finish/standby
// R11: done and busy flags are read-only
// R12: low result bits three-zero are unstable; code reads bit 3 as zero
// R13: control two bits seven-six read undefined
// R14: software writes bit0 zero, bit4 one
// R15: ladder bit keeps ladder always connected
// R16: time code selects 39..1248 clock periods; code runs ten steps of a tenth rounded down, 30..1240
// R17: software avoids reserved time codes
// R18: change channel only while not busy
// R19: standby resets control registers, blocks writes
// R20: software disables inputs when none used
// R21: repeat mode restarts after each completion
// R22: writing off mode aborts, no result stored
// R23: new start clears done, keeps old result
// R24: ten decisions msb first, then complete
`timescale 1ns/10ps
`include "sacs_consts.vh"
module sacs_sequencer (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // avalon-mm slave
   input wire [`SACS_ADDR_W-1:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   // power state
   input wire standby,
   // analog side
   input wire compHigh,
   output reg [3:0] channelSel,
   output reg inputDisable,
   output reg ladderOn,
   output reg sampleOn,
   output reg [9:0] trialCode,
   output reg conversionCompleteIrq
);
   localparam IDLE = 1'b0;
   localparam CONV = 1'b1;

   reg [7:0] ctrlOne;
   reg [5:0] ctrlTwo;
   reg [9:0] result;
   reg doneFlag;
   reg busyFlag;
   reg state;
   reg [9:0] sar;
   reg [3:0] bitIdx;
   reg [10:0] cycCnt;
   reg [10:0] stepLen;
   reg ackPend;
   reg [2:0] unstable;
   reg [10:0] periods;

   wire [1:0] mode = ctrlOne[`SACS_C1_MODE_HI:`SACS_C1_MODE_LO];
   wire [2:0] timeCode = ctrlTwo[`SACS_C2_TIME_HI:`SACS_C2_TIME_LO];
   // writes and the clearing read land on the edge after the wait, while waitrequest is low
   wire wrCtrlOne = write && ackPend && address == `SACS_ADDR_CTRL1;
   wire wrCtrlTwo = write && ackPend && address == `SACS_ADDR_CTRL2;
   wire rdResHi = read && ackPend && address == `SACS_ADDR_RESHI;
   // R1: single-mode start; R21 repeat also started by the bit
   wire startReq = ctrlOne[`SACS_C1_START] && state == IDLE &&
      (mode == `SACS_MODE_SINGLE || mode == `SACS_MODE_REPEAT);
   wire stepEnd = state == CONV && cycCnt == 11'h001;
   wire lastBit = bitIdx == 4'h0;
   wire bitOne = stepEnd && compHigh;
   // R24: decision for the bit under trial
   wire [9:0] sarNext = bitOne ? sar : (sar & ~(10'h001 << bitIdx));
   wire finish = stepEnd && lastBit;
   // R22: off mode written during conversion aborts
   wire abortNow = state == CONV && mode == `SACS_MODE_OFF;

   // one-cycle wait state: answer on the edge after the request
   assign waitrequest = (read || write) && !ackPend;

   // R16: conversion time per code; reserved codes fall back
   always @* begin
      case (timeCode)
         3'h0: periods = `SACS_T0;
         3'h2: periods = `SACS_T2;
         3'h3: periods = `SACS_T3;
         3'h4: periods = `SACS_T4;
         3'h5: periods = `SACS_T5;
         3'h6: periods = `SACS_T6;
         default: periods = `SACS_T6;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ackPend <= 1'b0;
         readdata <= 32'h0000_0000;
         unstable <= 3'h0;
      end else begin
         ackPend <= (read || write) && !ackPend;
         unstable <= unstable + 3'h1;
         if (read && !ackPend) begin
            case (address)
               `SACS_ADDR_CTRL1: readdata <= {24'h0, ctrlOne};
               // R13: top bits of control two read as free bits
               `SACS_ADDR_CTRL2:
                  readdata <= {24'h0, unstable[1:0], ctrlTwo};
               // R8: low result bits and flags; R12 bits 2-0 unstable, bit 3 zero
               // R11: flags come only from hardware
               `SACS_ADDR_RESLO:
                  readdata <= {24'h0, result[1:0], doneFlag, busyFlag,
                     1'b0, unstable};
               `SACS_ADDR_RESHI: readdata <= {24'h0, result[9:2]};
               default: readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlOne <= `SACS_CTRL1_RST;
         ctrlTwo <= `SACS_CTRL2_RST;
      end else if (standby) begin
         // R19: standby forces defaults and drops writes
         ctrlOne <= `SACS_CTRL1_RST;
         ctrlTwo <= `SACS_CTRL2_RST;
      end else begin
         if (wrCtrlOne)
            ctrlOne <= writedata[7:0];
         // R5: start bit cleared once conversion starts
         else if (startReq)
            ctrlOne[`SACS_C1_START] <= 1'b0;
         if (wrCtrlTwo)
            ctrlTwo <= writedata[5:0];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= IDLE;
         sar <= 10'h000;
         bitIdx <= 4'h0;
         cycCnt <= 11'h000;
         stepLen <= 11'h000;
         result <= {`SACS_RESHI_RST, 2'h0};
         doneFlag <= 1'b0;
         busyFlag <= 1'b0;
         conversionCompleteIrq <= 1'b0;
      end else begin
         conversionCompleteIrq <= 1'b0;
         if (standby) begin
            // R10: busy dropped on standby; results discarded
            state <= IDLE;
            busyFlag <= 1'b0;
            doneFlag <= 1'b0;
            result <= {`SACS_RESHI_RST, 2'h0};
         end else if (abortNow) begin
            state <= IDLE;
            busyFlag <= 1'b0;
         end else if (finish) begin
            // R7: result, done flag and interrupt together
            result <= sarNext;
            doneFlag <= 1'b1;
            conversionCompleteIrq <= 1'b1;
            // R21: repeat mode chains the next conversion
            if (mode == `SACS_MODE_REPEAT) begin
               sar <= 10'h200;
               bitIdx <= `SACS_NBITS - 4'h1;
               cycCnt <= stepLen;
            end else begin
               state <= IDLE;
               busyFlag <= 1'b0;
            end
         end else if (startReq) begin
            // R10: busy set at start
            // R23: done cleared, old result kept
            state <= CONV;
            busyFlag <= 1'b1;
            doneFlag <= 1'b0;
            sar <= 10'h200;
            bitIdx <= `SACS_NBITS - 4'h1;
            stepLen <= periods / {7'h0, `SACS_NBITS};
            cycCnt <= periods / {7'h0, `SACS_NBITS};
         end else if (stepEnd) begin
            // R24: keep or drop bit, then try the next lower
            sar <= sarNext | (10'h001 << (bitIdx - 4'h1));
            bitIdx <= bitIdx - 4'h1;
            cycCnt <= stepLen;
         end else if (state == CONV) begin
            cycCnt <= cycCnt - 11'h001;
         end else if (rdResHi) begin
            // R9: reading the high result clears done, reached only while idle
            doneFlag <= 1'b0;
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         channelSel <= 4'h0;
         inputDisable <= 1'b1;
         ladderOn <= 1'b0;
         sampleOn <= 1'b0;
         trialCode <= 10'h000;
      end else begin
         // R3: channel code passed straight to the mux
         channelSel <= ctrlOne[`SACS_C1_CH_HI:0];
         // R4: analog input disable
         inputDisable <= ctrlOne[`SACS_C1_AINDIS];
         // R15: ladder always on or only while converting
         ladderOn <= ctrlTwo[`SACS_C2_LADDER] || state == CONV;
         sampleOn <= state == CONV;
         trialCode <= sar;
      end
   end
endmodule

// [bench/sacs_sequencer_properties.sv]
// checker: bus handshake and control outputs of the sequencer
`timescale 1ns/10ps
`include "sacs_consts.vh"
module sacs_seq_props (
   // clock, reset and bus
   input wire clk,
   input wire rst_n,
   input wire [`SACS_ADDR_W-1:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire waitrequest,
   // power and analog side
   input wire standby,
   input wire [3:0] channelSel,
   input wire inputDisable,
   input wire ladderOn,
   input wire conversionCompleteIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire wr1 = write && !waitrequest && !standby
      && address == `SACS_ADDR_CTRL1;
   wire wr2 = write && !waitrequest && !standby
      && address == `SACS_ADDR_CTRL2;
   wait_first_a: assert property ($rose(read | write) |-> waitrequest)
      else $error("no wait state on new request");
   wait_once_a: assert property ((read | write) && waitrequest |=> !waitrequest)
      else $error("more than one wait state");
   irq_pulse_a: assert property (conversionCompleteIrq |=> !conversionCompleteIrq)
      else $error("interrupt longer than one cycle");
   chan_follow_a: assert property (wr1 |=> ##1
      channelSel == $past(writedata[3:0], 2))
      else $error("channel output not updated");
   input_dis_a: assert property (wr1 |=> ##1
      inputDisable == $past(writedata[4], 2))
      else $error("input disable not updated");
   ladder_on_a: assert property (wr2 && writedata[5] |=> ##1 ladderOn)
      else $error("ladder not held connected");
   standby_clr_a: assert property (standby |=> ##1
      inputDisable && channelSel == 4'h0)
      else $error("standby did not reset control");
   abort_quiet_a: assert property (wr1 && writedata[6:5] == 2'h0
      |=> ##1 !conversionCompleteIrq [*6])
      else $error("interrupt after abort");
   upper_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   cover property (conversionCompleteIrq);
   cover property (standby);
   cover property (wr1 && writedata[6:5] == 2'h3);
endmodule
bind sacs_sequencer sacs_seq_props chk (.clk(clk), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .standby(standby),
   .channelSel(channelSel), .inputDisable(inputDisable), .ladderOn(ladderOn),
   .conversionCompleteIrq(conversionCompleteIrq));

// [bench/test_sar_adc_control_sequencer.sv]
// self-checking bench for the converter control sequencer
`timescale 1ns/10ps
`include "sacs_consts.vh"
module test_sar_adc_control_sequencer;
   logic clk = 0, rst_n = 0, read = 0, write = 0, standby = 0, compHigh = 0;
   logic [`SACS_ADDR_W-1:0] address = '0;
   logic [31:0] writedata = '0;
   wire [31:0] readdata;
   wire waitrequest, inputDisable, ladderOn, sampleOn, irq;
   wire [3:0] channelSel;
   wire [9:0] trialCode;
   logic [9:0] tgt = '0;
   logic [7:0] q;
   int err_total = 0, num_checks = 0, cnt;
   time t0;
   sacs_sequencer uut (.clk(clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .standby(standby), .compHigh(compHigh),
      .channelSel(channelSel), .inputDisable(inputDisable),
      .ladderOn(ladderOn), .sampleOn(sampleOn), .trialCode(trialCode),
      .conversionCompleteIrq(irq));
   initial forever #2 clk = ~clk;
   // comparator: input voltage stands at tgt
   always @(posedge clk) compHigh <= trialCode <= tgt;
   // reserved codes run the longest time
   function automatic int ptime(input logic [2:0] c);
      return c == 0 ? 39 : (c > 1 && c < 6) ? 39 << (c - 1) : 1248;
   endfunction
   task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task bus(input logic we, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, d};
      read <= !we;
      write <= we;
      // sample waitrequest and read data on the rising edge itself
      do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 50);
      if (n >= 50)
         err_total++;
      q = readdata[7:0];
      read <= 0;
      write <= 0;
   endtask
   task waitirq;
      int n;
      n = 0;
      do @(negedge clk); while (irq !== 1'b1 && ++n < 1400);
      chk("irq", 10'h1, irq);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'hEBE8));
      repeat (3) @(posedge clk);
      rst_n <= 1;
      bus(0, `SACS_ADDR_CTRL1, 8'h00);
      chk("ctrl1", 8'h10, q);
      bus(0, `SACS_ADDR_RESHI, 8'h00);
      chk("reshi", 8'h00, q);
      bus(0, 10'h000, 8'h00);
      chk("unmapped", 8'h00, q);
      $display("test reset done");
      // every time code, corner and random levels
      for (int i = 0; i < 8; i++) begin
         tgt <= i == 0 ? 10'h3FF : i == 1 ? 10'h000 : 10'($urandom);
         bus(1, `SACS_ADDR_CTRL2, {2'h0, i[0], 1'b1, i[2:0], 1'b0});
         bus(1, `SACS_ADDR_CTRL1, {4'hA, 4'($urandom)});
         t0 = $time;
         bus(0, `SACS_ADDR_RESLO, 8'h00);
         chk("busy", 10'h1, q[4]);
         bus(0, `SACS_ADDR_CTRL1, 8'h00);
         chk("start", 10'h0, q[7]);
         waitirq;
         cnt = ($time - t0) / 4 - ptime(i[2:0]) / 10 * 10;
         chk("time", 10'h1, cnt >= -3 && cnt <= 4);
         bus(0, `SACS_ADDR_RESLO, 8'h00);
         chk("reslo", {tgt[1:0], 2'h2}, q[7:4]);
         bus(0, `SACS_ADDR_RESHI, 8'h00);
         chk("reshi", tgt[9:2], q);
         bus(0, `SACS_ADDR_RESLO, 8'h00);
         chk("done", 10'h0, q[5]);
      end
      $display("test single done");
      tgt <= 10'h155;
      bus(1, `SACS_ADDR_CTRL1, 8'hE5);
      waitirq;
      waitirq;
      // partial value must never land
      tgt <= 10'h2AA;
      bus(1, `SACS_ADDR_CTRL1, 8'h05);
      repeat (1300) @(posedge clk);
      bus(0, `SACS_ADDR_RESLO, 8'h00);
      chk("busy", 10'h0, q[4]);
      bus(0, `SACS_ADDR_RESHI, 8'h00);
      chk("reshi", 8'h55, q);
      $display("test repeat done");
      bus(1, `SACS_ADDR_CTRL1, 8'hAA);
      standby <= 1;
      bus(1, `SACS_ADDR_CTRL1, 8'h0F);
      standby <= 0;
      bus(0, `SACS_ADDR_CTRL1, 8'h00);
      chk("ctrl1", 8'h10, q);
      bus(0, `SACS_ADDR_RESLO, 8'h00);
      chk("busy", 10'h0, q[4]);
      $display("test standby done");
      wrap_up;
   end
endmodule
